// >>> logic/ckx2_top.v
// Overview of operation
// - Oscillator feeds PLL, CPU, peripheral clocks.
// - Each clock gated by power mode.
// - Peripheral clock drives timers, card, SPI, ports.
// - Machine cycle is 12 or 6 periods.
// - CPU and peripheral rates change together.
// - Standard mode after reset unless fuse.
// - Standard divides oscillator by two.
// - Fuse sets reset speed on flash variants.
// - PLL clock feeds audio and USB.
// - Detector compares reference and feedback dividers.
// - PLL runs only while enabled.
// - Lock flag set once locked.
// - Speed select is clock control bit 0.
// - PLL control bit layout fixed.
`timescale 1ns/1ns
`default_nettype none
`include "ckx2_defs.vh"
module ckx2_top #(
   parameter HAS_FUSE = 1, // Flash variant with boot speed fuse.
   parameter [7:0] NDIV = `CKX2_NDIV // PLL reference divider.
) (
   input wire clk_i, // Oscillator clock, 50 MHz.
   input wire rst_i, // Synchronous reset, active high.
   input wire ce_i, // Clock enable, freezes all state.
   input wire wb_cyc_i, // Wishbone cycle.
   input wire wb_stb_i, // Wishbone strobe.
   input wire wb_we_i, // Wishbone write.
   input wire [7:0] wb_adr_i, // Wishbone byte address.
   input wire [3:0] wb_sel_i, // Wishbone byte enables.
   input wire [31:0] wb_dat_i, // Wishbone write data.
   output wire [31:0] wb_dat_o, // Wishbone read data.
   output wire wb_ack_o, // Wishbone acknowledge.
   input wire boot_speed_fuse_i, // Fuse pin, asynchronous.
   input wire idle_mode_i, // Idle power mode request.
   input wire power_down_i, // Power down request.
   output reg pll_osc_en_o, // Oscillator clock to PLL enabled.
   output wire cpu_clk_en_o, // CPU clock enable pulse.
   output wire per_clk_en_o, // Peripheral clock enable pulse.
   output wire machine_cycle_o, // Machine cycle end pulse.
   output reg [4:0] per_tick_o, // Timer0, timer1, card, SPI, port ticks.
   output wire pll_clk_o, // PLL clock for audio and USB.
   output wire pll_up_o, // Detector speed up pulse.
   output wire pll_down_o, // Detector slow down pulse.
   output wire double_speed_o, // Double speed mode in force.
   output wire irq_o // Interrupt, active high level.
);
   reg ds_ff; // Requested double speed select.
   reg pll_en_ff; // PLL enable bit.
   reg pll_res_ff; // PLL reset bit.
   reg [1:0] rdiv_ff; // PLL feedback divider bits.
   reg [2:0] istat_ff; // Sticky interrupt status.
   reg [2:0] imask_ff; // Interrupt mask.
   reg [4:0] perce_ff; // Per consumer peripheral tick enables.
   reg [31:0] rdat_ff; // Read data register.
   reg ack_ff; // Acknowledge register.
   reg fuse_s1_ff; // Fuse synchroniser first stage.
   reg fuse_s2_ff; // Fuse synchroniser second stage.
   reg [1:0] boot_ff; // Cycles since reset release.
   reg lock_d_ff; // Lock flag delayed for edge detect.
   wire req; // New bus request.
   wire wr; // Write to low byte lane.
   wire pll_lock; // Lock flag from the PLL.
   wire sw_pulse; // Speed mode switched.
   wire per_tick; // Peripheral clock enable.
   wire cpu_on; // CPU clock allowed.
   wire osc_run; // Oscillator clocks running.
   wire [2:0] ev; // Interrupt events this cycle.
   wire [2:0] w1c; // Status bits cleared by software.
   reg [31:0] nxt_rdat; // Read mux result.

   // A request is answered in the cycle after it is seen, so ack lags one cycle.
   assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign osc_run = ~power_down_i;
   assign cpu_on = ~idle_mode_i & ~power_down_i;
   assign per_clk_en_o = per_tick;
   assign ev = {sw_pulse, lock_d_ff & ~pll_lock, ~lock_d_ff & pll_lock};
   assign w1c = (wr && wb_adr_i == `CKX2_OFS_ISTAT) ? wb_dat_i[2:0] : 3'h0;
   assign irq_o = |(istat_ff & imask_ff);

   // Fuse pin crosses into the clock domain through two flip-flops.
   always @(posedge clk_i) begin
      if (rst_i) begin
         fuse_s1_ff <= 1'b0;
         fuse_s2_ff <= 1'b0;
      end else if (ce_i) begin
         fuse_s1_ff <= boot_speed_fuse_i;
         fuse_s2_ff <= fuse_s1_ff;
      end
   end

   // Bus slave: acknowledge every access, unmapped addresses read zero and ignore writes.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else if (ce_i) begin
         ack_ff <= req;
         if (req && !wb_we_i) begin
            rdat_ff <= nxt_rdat;
         end
      end
   end

   // Read mux; reserved bits read zero.
   always @* begin
      nxt_rdat = 32'h00000000;
      case (wb_adr_i)
         `CKX2_OFS_CLKCTL: nxt_rdat[`CKX2_DS_BIT] = ds_ff;
         `CKX2_OFS_PLLCTL: begin
            nxt_rdat[`CKX2_RDIV_MSB:`CKX2_RDIV_LSB] = rdiv_ff;
            nxt_rdat[`CKX2_RES_BIT] = pll_res_ff;
            nxt_rdat[`CKX2_EN_BIT] = pll_en_ff;
            nxt_rdat[`CKX2_LOCK_BIT] = pll_lock;
         end
         `CKX2_OFS_ISTAT: nxt_rdat[2:0] = istat_ff;
         `CKX2_OFS_IMASK: nxt_rdat[2:0] = imask_ff;
         `CKX2_OFS_STATE: nxt_rdat[1:0] = {cpu_on, double_speed_o};
         `CKX2_OFS_PERCE: nxt_rdat[4:0] = perce_ff;
         default: nxt_rdat = 32'h00000000;
      endcase
   end

   // Control registers; the boot fuse is taken once the synchroniser has settled.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ds_ff <= `CKX2_CLKCTL_RST;
         boot_ff <= 2'h0;
         pll_en_ff <= `CKX2_PLL_ENABLE_BIT_RST;
         pll_res_ff <= `CKX2_PLL_RESET_BIT_RST;
         rdiv_ff <= `CKX2_RDIV_RST;
         imask_ff <= `CKX2_IMASK_RST;
         perce_ff <= `CKX2_PERCE_RST;
      end else if (ce_i) begin
         if (boot_ff != `CKX2_BOOT_CYC) begin
            boot_ff <= boot_ff + 2'h1;
         end
         if ((boot_ff == `CKX2_BOOT_CYC - 2'h1) && (HAS_FUSE != 0)) begin
            ds_ff <= fuse_s2_ff;
         end
         if (wr) begin
            case (wb_adr_i)
               `CKX2_OFS_CLKCTL: ds_ff <= wb_dat_i[`CKX2_DS_BIT];
               `CKX2_OFS_PLLCTL: begin
                  rdiv_ff <= wb_dat_i[`CKX2_RDIV_MSB:`CKX2_RDIV_LSB];
                  pll_res_ff <= wb_dat_i[`CKX2_RES_BIT];
                  pll_en_ff <= wb_dat_i[`CKX2_EN_BIT];
               end
               `CKX2_OFS_IMASK: imask_ff <= wb_dat_i[2:0];
               `CKX2_OFS_PERCE: perce_ff <= wb_dat_i[4:0];
               default: ;
            endcase
         end
      end
   end

   // Sticky status: a new event in the same cycle as its clear keeps the bit set.
   always @(posedge clk_i) begin
      if (rst_i) begin
         istat_ff <= 3'h0;
         lock_d_ff <= 1'b0;
      end else if (ce_i) begin
         lock_d_ff <= pll_lock;
         istat_ff <= (istat_ff & ~w1c) | ev;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pll_osc_en_o <= 1'b0;
      end else if (ce_i) begin
         pll_osc_en_o <= osc_run;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_per
         always @(posedge clk_i) begin
            if (rst_i) begin
               per_tick_o[gi] <= 1'b0;
            end else if (ce_i) begin
               per_tick_o[gi] <= per_tick & perce_ff[gi];
            end
         end
      end
   endgenerate

   ckx2_clkdiv u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .ds_req_i(ds_ff),
      .osc_run_i(osc_run),
      .cpu_on_i(cpu_on),
      .cpu_tick_o(cpu_clk_en_o),
      .per_tick_o(per_tick),
      .mcycle_o(machine_cycle_o),
      .switch_o(sw_pulse),
      .ds_act_o(double_speed_o)
   );

   ckx2_pll #(
      .NDIV(NDIV)
   ) u_pll (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .run_i(pll_en_ff & ~pll_res_ff & osc_run),
      .rdiv_i(rdiv_ff),
      .pll_clk_o(pll_clk_o),
      .up_o(pll_up_o),
      .down_o(pll_down_o),
      .lock_o(pll_lock)
   );
endmodule // ckx2_top
`default_nettype wire

// >>> logic/ckx2_defs.vh
`ifndef CKX2_DEFS_VH
`define CKX2_DEFS_VH
// Register byte offsets on the Wishbone bus.
`define CKX2_OFS_CLKCTL 8'h00
`define CKX2_OFS_PLLCTL 8'h04
`define CKX2_OFS_ISTAT 8'h08
`define CKX2_OFS_IMASK 8'h0C
`define CKX2_OFS_STATE 8'h10
`define CKX2_OFS_PERCE 8'h14
// Field positions.
`define CKX2_DS_BIT 0
`define CKX2_LOCK_BIT 0
`define CKX2_EN_BIT 1
`define CKX2_RES_BIT 3
`define CKX2_RDIV_LSB 6
`define CKX2_RDIV_MSB 7
`define CKX2_IRQ_LOCK_BIT 0
`define CKX2_IRQ_LOSS_BIT 1
`define CKX2_IRQ_SWITCH_BIT 2
// Reset values.
`define CKX2_CLKCTL_RST 1'h0
`define CKX2_PLL_ENABLE_BIT_RST 1'h0
`define CKX2_PLL_RESET_BIT_RST 1'h0
`define CKX2_RDIV_RST 2'h0
`define CKX2_IMASK_RST 3'h0
`define CKX2_PERCE_RST 5'h1F
// Timing counts.
`define CKX2_BOOT_CYC 2'h3
`define CKX2_MCYC_LAST 3'h5
`define CKX2_LOCK_CNT 5'h10
`define CKX2_NDIV 8'h10
`define CKX2_FW_INIT 16'h0800
`define CKX2_FW_STEP 16'h0100
`define CKX2_FW_MAX 16'h7FF0
`endif

// >>> logic/ckx2_clkdiv.v
`timescale 1ns/1ns
`default_nettype none
// Machine clock divider: turns the oscillator into CPU and peripheral clock
// enables, and swaps the speed mode only at the end of a machine cycle.
`include "ckx2_defs.vh"
module ckx2_clkdiv (
   input wire clk_i, // Oscillator clock.
   input wire rst_i, // Synchronous reset, active high.
   input wire ce_i, // Clock enable, freezes state when low.
   input wire ds_req_i, // Requested double speed mode.
   input wire osc_run_i, // Oscillator clocks running (not power down).
   input wire cpu_on_i, // CPU clock allowed by power mode.
   output reg cpu_tick_o, // CPU clock enable pulse.
   output reg per_tick_o, // Peripheral clock enable pulse.
   output reg mcycle_o, // Machine cycle end pulse.
   output reg switch_o, // Pulse when the speed mode changed.
   output wire ds_act_o // Speed mode now in force.
);
   reg half_ff; // Phase of the divide by two.
   reg ds_act_ff; // Active double speed mode.
   reg [2:0] tcnt_ff; // Ticks within a machine cycle.
   wire tick; // One tick of the shared CPU and peripheral clock.
   wire mc_end; // Last tick of a machine cycle.

   assign ds_act_o = ds_act_ff;
   // Divide by two only in standard mode.
   assign tick = osc_run_i & (ds_act_ff | half_ff);
   assign mc_end = tick & (tcnt_ff == `CKX2_MCYC_LAST);

   // One shared tick drives both clocks, so a running CPU clock never differs in rate from the peripheral clock.
   always @(posedge clk_i) begin
      if (rst_i) begin
         half_ff <= 1'b0;
         ds_act_ff <= 1'b0;
         tcnt_ff <= 3'h0;
         cpu_tick_o <= 1'b0;
         per_tick_o <= 1'b0;
         mcycle_o <= 1'b0;
         switch_o <= 1'b0;
      end else if (ce_i) begin
         cpu_tick_o <= tick & cpu_on_i;
         per_tick_o <= tick;
         mcycle_o <= mc_end;
         switch_o <= 1'b0;
         if (tick) begin
            tcnt_ff <= mc_end ? 3'h0 : tcnt_ff + 3'h1;
         end
         if (osc_run_i) begin
            half_ff <= ds_act_ff ? 1'b0 : ~half_ff;
         end
         if (mc_end && (ds_act_ff != ds_req_i)) begin
            ds_act_ff <= ds_req_i;
            half_ff <= 1'b0;
            switch_o <= 1'b1;
         end
      end
   end
endmodule // ckx2_clkdiv
`default_nettype wire

// >>> logic/ckx2_pll.v
`timescale 1ns/1ns
`default_nettype none
// Digital model of the PLL: an accumulator oscillator steered by a
// frequency comparator between the N divided reference and the R divided feedback.
`include "ckx2_defs.vh"
module ckx2_pll #(
   parameter [7:0] NDIV = `CKX2_NDIV // Reference divider.
) (
   input wire clk_i, // Oscillator clock.
   input wire rst_i, // Synchronous reset, active high.
   input wire ce_i, // Clock enable.
   input wire run_i, // Enable and not held in reset.
   input wire [1:0] rdiv_i, // Feedback divider minus one.
   output wire pll_clk_o, // PLL clock.
   output reg up_o, // Speed up pulse.
   output reg down_o, // Slow down pulse.
   output reg lock_o // Lock detected.
);
   reg [7:0] ncnt_ff; // Reference divider count.
   reg [15:0] acc_ff; // Oscillator phase.
   reg [15:0] fw_ff; // Oscillator frequency word.
   reg [1:0] rcnt_ff; // Feedback divider count.
   reg [1:0] fbn_ff; // Feedback edges in this reference period.
   reg [4:0] lcnt_ff; // Good periods in a row.
   wire [15:0] nxt_acc; // Next phase.
   wire ref_edge; // Reference edge.
   wire fb_edge; // Feedback edge.

   assign nxt_acc = acc_ff + fw_ff;
   assign pll_clk_o = acc_ff[15];
   assign ref_edge = (ncnt_ff == NDIV - 8'h01);
   assign fb_edge = ~acc_ff[15] & nxt_acc[15] & (rcnt_ff == rdiv_i);

   // Disabled or in reset the oscillator stops and the lock is lost.
   always @(posedge clk_i) begin
      if (rst_i || (ce_i && !run_i)) begin
         ncnt_ff <= 8'h00;
         acc_ff <= 16'h0000;
         fw_ff <= `CKX2_FW_INIT;
         rcnt_ff <= 2'h0;
         fbn_ff <= 2'h0;
         lcnt_ff <= 5'h00;
         up_o <= 1'b0;
         down_o <= 1'b0;
         lock_o <= 1'b0;
      end else if (ce_i) begin
         acc_ff <= nxt_acc;
         ncnt_ff <= ref_edge ? 8'h00 : ncnt_ff + 8'h01;
         if (~acc_ff[15] & nxt_acc[15]) begin
            rcnt_ff <= fb_edge ? 2'h0 : rcnt_ff + 2'h1;
         end
         up_o <= 1'b0;
         down_o <= 1'b0;
         if (ref_edge) begin
            fbn_ff <= {1'b0, fb_edge};
            case (fbn_ff)
               2'h0: begin
                  up_o <= 1'b1;
                  lcnt_ff <= 5'h00;
                  if (fw_ff < `CKX2_FW_MAX) begin
                     fw_ff <= fw_ff + `CKX2_FW_STEP;
                  end
               end
               2'h1: begin
                  if (lcnt_ff != `CKX2_LOCK_CNT) begin
                     lcnt_ff <= lcnt_ff + 5'h01;
                  end
               end
               default: begin
                  down_o <= 1'b1;
                  lcnt_ff <= 5'h00;
                  if (fw_ff > `CKX2_FW_STEP) begin
                     fw_ff <= fw_ff - `CKX2_FW_STEP;
                  end
               end
            endcase
         end else if (fb_edge && (fbn_ff != 2'h2)) begin
            fbn_ff <= fbn_ff + 2'h1;
         end
         lock_o <= (lcnt_ff == `CKX2_LOCK_CNT);
      end
   end
endmodule // ckx2_pll
`default_nettype wire

// >>> bench/ckx2_props.sv
`timescale 1ns/1ns
`default_nettype none
module ckx2_props (
   input wire logic clk_i, // Oscillator clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic ce_i, // Clock enable.
   input wire logic wb_cyc_i, // Bus cycle.
   input wire logic wb_stb_i, // Bus strobe.
   input wire logic wb_we_i, // Bus write.
   input wire logic [7:0] wb_adr_i, // Bus address.
   input wire logic [3:0] wb_sel_i, // Byte enables.
   input wire logic [31:0] wb_dat_i, // Write data.
   input wire logic wb_ack_o, // Acknowledge.
   input wire logic idle_mode_i, // Idle request.
   input wire logic power_down_i, // Power down request.
   input wire logic pll_osc_en_o, // PLL oscillator gate.
   input wire logic cpu_clk_en_o, // CPU tick.
   input wire logic per_clk_en_o, // Peripheral tick.
   input wire logic machine_cycle_o, // Machine cycle end.
   input wire logic [4:0] per_tick_o, // Peripheral unit ticks.
   input wire logic pll_clk_o, // PLL clock.
   input wire logic double_speed_o, // Speed mode.
   input wire logic irq_o // Interrupt.
);
   logic run_ff; // PLL enabled and not held in reset, mirrored from writes.
   logic [2:0] mask_ff; // Interrupt mask mirror.
   logic take; // A write is taken at this edge.
   assign take = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   // Mirrors follow the taking edge, just as the registers do.
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_ff <= 1'b0;
         mask_ff <= 3'h0;
      end else if (take && wb_adr_i == 8'h04) begin
         run_ff <= wb_dat_i[1] && !wb_dat_i[3];
      end else if (take && wb_adr_i == 8'h0C) begin
         mask_ff <= wb_dat_i[2:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   tick_pair_a: assert property (cpu_clk_en_o |-> per_clk_en_o)
      else $error("cpu tick alone");
   std_rate_a: assert property (per_clk_en_o && !double_speed_o ##1 !double_speed_o |-> !per_clk_en_o)
      else $error("standard tick rate");
   dbl_rate_a: assert property ((double_speed_o && !power_down_i)[*3] |-> per_clk_en_o)
      else $error("double tick rate");
   mcyc_std_a: assert property (disable iff (rst_i || power_down_i)
      machine_cycle_o ##1 !double_speed_o |-> ##11 machine_cycle_o) else $error("standard machine cycle");
   mcyc_dbl_a: assert property (disable iff (rst_i || power_down_i)
      machine_cycle_o ##1 double_speed_o |-> ##5 machine_cycle_o) else $error("double machine cycle");
   idle_cpu_a: assert property (idle_mode_i[*3] |-> !cpu_clk_en_o)
      else $error("cpu runs in idle");
   pdown_stop_a: assert property (power_down_i[*3] |-> !per_clk_en_o && !machine_cycle_o)
      else $error("ticks in power down");
   osc_gate_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> pll_osc_en_o == !$past(power_down_i))
      else $error("pll oscillator gate");
   per_src_a: assert property (|per_tick_o |-> $past(per_clk_en_o))
      else $error("unit tick without source");
   pll_stop_a: assert property ((!run_ff)[*4] |-> $stable(pll_clk_o))
      else $error("pll clock while disabled");
   irq_mask_a: assert property (mask_ff == 3'h0 |-> !irq_o) else $error("masked interrupt");
   switch_c: cover property ($rose(double_speed_o));
   irq_c: cover property ($rose(irq_o));
   pll_c: cover property (run_ff && $changed(pll_clk_o));
endmodule // ckx2_props
bind ckx2_top ckx2_props props_u (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_ack_o, .idle_mode_i, .power_down_i, .pll_osc_en_o, .cpu_clk_en_o,
   .per_clk_en_o, .machine_cycle_o, .per_tick_o, .pll_clk_o, .double_speed_o, .irq_o);
`default_nettype wire

// >>> bench/ckx2_consumer.sv
`timescale 1ns/1ns
`default_nettype none
module ckx2_consumer (
   input wire logic clk_i, // Oscillator clock.
   input wire logic cpu_en_i, // CPU clock enable.
   input wire logic per_en_i, // Peripheral clock enable.
   output logic [15:0] cpu_cnt_o = 16'h0, // CPU steps taken.
   output logic [15:0] per_cnt_o = 16'h0 // Peripheral steps taken.
);
   // consumers step only on their enables
   always @(posedge clk_i) begin
      cpu_cnt_o <= cpu_cnt_o + {15'h0, cpu_en_i};
      per_cnt_o <= per_cnt_o + {15'h0, per_en_i};
   end
endmodule // ckx2_consumer
`default_nettype wire

// >>> bench/ckx2_tb.sv
`timescale 1ns/1ns
`default_nettype none
module clock_x2_pll_control_test;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1; // Clock, reset, enable.
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0; // Bus controls.
   logic [7:0] wb_adr_i = 8'h00; // Bus address.
   logic [3:0] wb_sel_i = 4'hF; // Byte enables.
   logic [31:0] wb_dat_i = 32'h0; // Write data.
   logic boot_speed_fuse_i = 1'b0, idle_mode_i = 1'b0, power_down_i = 1'b0; // Mode pins.
   wire [31:0] wb_dat_o; // Read data.
   wire [4:0] per_tick_o; // Unit ticks.
   wire wb_ack_o, pll_osc_en_o, cpu_clk_en_o, per_clk_en_o, machine_cycle_o; // Outputs.
   wire pll_clk_o, pll_up_o, pll_down_o, double_speed_o, irq_o; // Outputs.
   wire [15:0] cpu_cnt, per_cnt; // Consumer step counts.
   integer bad_count = 0, compares = 0; // Tallies.
   logic up_seen = 1'b0, down_seen = 1'b0; // Detector pulses seen since start.
   always #10 clk_i = ~clk_i;
   // Remember any detector pulse, since each one stands for a single cycle only.
   always @(posedge clk_i) begin
      if (pll_up_o === 1'b1) begin
         up_seen <= 1'b1;
      end
      if (pll_down_o === 1'b1) begin
         down_seen <= 1'b1;
      end
   end
   ckx2_top #(.HAS_FUSE(1)) dut_u (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .boot_speed_fuse_i, .idle_mode_i, .power_down_i,
      .pll_osc_en_o, .cpu_clk_en_o, .per_clk_en_o, .machine_cycle_o, .per_tick_o, .pll_clk_o,
      .pll_up_o, .pll_down_o, .double_speed_o, .irq_o);
   ckx2_consumer cons_u (.clk_i, .cpu_en_i(cpu_clk_en_o), .per_en_i(per_clk_en_o),
      .cpu_cnt_o(cpu_cnt), .per_cnt_o(per_cnt));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task test_done;
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // One classic cycle; the request stands until ack is seen, so a slow answer is fine.
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      integer n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk("ack", 32'h1, {31'h0, wb_ack_o});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk("read data", e, q & m);
   endtask
   // Counts consumer steps over 24 cycles, two standard machine cycles.
   task rate(input logic [15:0] ec, input logic [15:0] ep);
      logic [15:0] c, p;
      c = cpu_cnt;
      p = per_cnt;
      repeat (24) @(posedge clk_i);
      chk("cpu steps", {16'h0, ec}, {16'h0, cpu_cnt - c});
      chk("peripheral steps", {16'h0, ep}, {16'h0, per_cnt - p});
   endtask
   task wait_dbl(input logic v);
      integer n;
      n = 0;
      while (double_speed_o !== v && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      // One more edge, so the status bit set along with the switch can be seen.
      @(posedge clk_i);
      chk("speed mode", {31'h0, v}, {31'h0, double_speed_o});
   endtask
   task t_boot;
      chk("speed mode", 32'h0, {31'h0, double_speed_o});
      rdchk(8'h00, 32'hFF, 32'h0);
      rdchk(8'h04, 32'hFF, 32'h0);
      rdchk(8'h14, 32'h1F, 32'h1F);
      rdchk(8'h1C, 32'hFFFFFFFF, 32'h0);
      rate(16'd12, 16'd12);
   endtask
   task t_switch;
      wr(8'h0C, 32'h4);
      wr(8'h00, 32'h1);
      wait_dbl(1'b1);
      chk("irq", 32'h1, {31'h0, irq_o});
      rdchk(8'h08, 32'h4, 32'h4);
      rdchk(8'h10, 32'h1, 32'h1);
      rate(16'd24, 16'd24);
      wr(8'h08, 32'h4);
      chk("irq", 32'h0, {31'h0, irq_o});
      wr(8'h0C, 32'h0);
      wr(8'h00, 32'h0);
      wait_dbl(1'b0);
      rdchk(8'h08, 32'h4, 32'h4);
      chk("irq", 32'h0, {31'h0, irq_o});
      wr(8'h08, 32'h4);
      rate(16'd12, 16'd12);
   endtask
   task t_power;
      idle_mode_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rate(16'd0, 16'd12);
      idle_mode_i <= 1'b0;
      power_down_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rate(16'd0, 16'd0);
      chk("pll gate", 32'h0, {31'h0, pll_osc_en_o});
      power_down_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("pll gate", 32'h1, {31'h0, pll_osc_en_o});
   endtask
   task t_pll;
      logic [31:0] q;
      integer n;
      wr(8'h0C, 32'h3);
      wr(8'h04, 32'hC0);
      rdchk(8'h04, 32'hFF, 32'hC0);
      wr(8'h04, 32'h2);
      n = 0;
      q = 32'h0;
      while (q[0] !== 1'b1 && n < 1000) begin
         wb(1'b0, 8'h04, 32'h0, q);
         n++;
      end
      chk("lock flag", 32'h1, {31'h0, q[0]});
      chk("up pulses", 32'h1, {31'h0, up_seen});
      chk("down pulses", 32'h0, {31'h0, down_seen});
      rdchk(8'h08, 32'h1, 32'h1);
      chk("irq", 32'h1, {31'h0, irq_o});
      wr(8'h08, 32'h1);
      wr(8'h04, 32'h0);
      rdchk(8'h04, 32'h1, 32'h0);
      rdchk(8'h08, 32'h2, 32'h2);
      wr(8'h08, 32'h3);
      chk("irq", 32'h0, {31'h0, irq_o});
      wr(8'h0C, 32'h0);
   endtask
   task t_fuse;
      boot_speed_fuse_i <= 1'b1;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wait_dbl(1'b1);
      rdchk(8'h00, 32'h1, 32'h1);
      boot_speed_fuse_i <= 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      t_boot;
      t_switch;
      t_power;
      t_pll;
      t_fuse;
      test_done;
   end
   // A hang is cut short well past the few thousand cycles the tests need.
   initial begin
      #400000;
      bad_count++;
      test_done;
   end
endmodule // clock_x2_pll_control_test
`default_nettype wire
